// ### verilog/slc_consts.svh
`ifndef SLC_CONSTS_SVH
`define SLC_CONSTS_SVH

// ****************************************************
// Register map
// ****************************************************
`define SLC_REG_RATE 16'h0001
`define SLC_REG_LINK 16'h0010
`define SLC_REG_STATUS 16'h0013

// ****************************************************
// Reset values
// ****************************************************
`define SLC_RATE_RESET 8'h08
`define SLC_LINK_RESET 8'h10

// ****************************************************
// Field positions
// ****************************************************
`define SLC_BIT_ONESHOT 5
`define SLC_BIT_AUTO 4
`define SLC_TX_MSB 3
`define SLC_TX_LSB 2
`define SLC_RX_MSB 1
`define SLC_RX_LSB 0
`define SLC_CFG_MSB 1
`define SLC_CFG_LSB 0
`define SLC_STAT_LOCK 7
`define SLC_STAT_BUSY 6

// ****************************************************
// Field codes
// ****************************************************
`define SLC_CFG_DUAL 2'h0
`define SLC_CFG_FIRST 2'h1
`define SLC_CFG_SECOND 2'h2
`define SLC_CFG_SPLIT 2'h3
`define SLC_RATE_6G 2'h2
`define SLC_RATE_3G 2'h1
`define SLC_RATE_REV 2'h0
`define SLC_ONESHOT_MASK 8'h20

// ****************************************************
// Timing
// ****************************************************
`define SLC_CLK_HZ 10000000
`define SLC_CAL_TIME_US 5000
`define SLC_CAL_CYC (`SLC_CAL_TIME_US * (`SLC_CLK_HZ / 1000000))
`define SLC_ADAPT_TIME_US 10000
`define SLC_ADAPT_CYC (`SLC_ADAPT_TIME_US * (`SLC_CLK_HZ / 1000000))
`define SLC_SEQ_LIMIT_MS 50
`define SLC_SEQ_LIMIT_CYC (`SLC_SEQ_LIMIT_MS * (`SLC_CLK_HZ / 1000))

`endif

// ### verilog/slc_pkg.sv
package slc_pkg;

    // ****************************************************
    // Device sequence states, one-hot
    // ****************************************************
    typedef enum logic [6:0] {
        S_IDLE   = 7'h01,
        S_DETECT = 7'h02,
        S_RESET  = 7'h04,
        S_CALIB  = 7'h08,
        S_ADAPT  = 7'h10,
        S_LINKUP = 7'h20,
        S_LOCKED = 7'h40
    } slc_dev_state_t;

    // ****************************************************
    // Configuring end states, one-hot
    // ****************************************************
    typedef enum logic [2:0] {
        H_IDLE   = 3'h1,
        H_LINK   = 3'h2,
        H_WAITRD = 3'h4
    } slc_host_state_t;

    // Command kinds on the configuring end
    typedef enum logic {
        CMD_MODE = 1'b0,
        CMD_RATE = 1'b1
    } slc_cmd_t;

endpackage

// ### verilog/slc_reg_if.sv
`timescale 1ns/1ns

// ****************************************************
// Register access between configuring end and device
// ****************************************************
interface slc_reg_if;
    logic [15:0] regAddr; // Register address
    logic [7:0] regWrData; // Write byte
    logic regWrEn; // One-cycle write strobe
    logic regRdEn; // One-cycle read strobe
    logic [7:0] regRdData; // Read byte
    logic regRdValid; // Read answer strobe

    modport dev (
        input regAddr,
        input regWrData,
        input regWrEn,
        input regRdEn,
        output regRdData,
        output regRdValid
    );

    modport host (
        output regAddr,
        output regWrData,
        output regWrEn,
        output regRdEn,
        input regRdData,
        input regRdValid
    );
endinterface

// ### verilog/slc_device_end.sv
`timescale 1ns/1ns
`include "slc_consts.svh"

// Behaviour
// - Forward rate code 10 is 6G, 01 3G
// - Reverse rate code 00 runs 187.5 Mb/s
// - New settings apply only at one-shot reset
// - Automatic link selection bit resets to one
// - Auto mode takes first detected port only
// - Auto mode ignores manual link field
// - Manual codes: 01 first, 10 second, 11 split
// - Reverse splitter serializers run single-link each
// - Software writes one-shot bit after changes
// - Writes 0x21/0x22 pick port and reset
// - Ordered reset sequence completes within 50 ms
// - Write 0x30 detects port, then same steps
// - Single-link mode holds until splitter rewritten
// - Write 0x23 resets into splitter mode
// - Single-port part supports single-link mode only
// - Software should keep automatic selection normally
// - 0x00 selects dual, 0x20 fires reset
// - Rate register accepts 0x48 and 0x02
// - Lock needs PLL lock and word alignment
module slc_device_end
    import slc_pkg::*;
#(
    parameter bit IS_SERIALIZER = 1'b1,
    parameter int NUM_PHYS = 2,
    parameter int CAL_CYCLES = `SLC_CAL_CYC,
    parameter int ADAPT_CYCLES = `SLC_ADAPT_CYC,
    parameter int LIMIT_CYCLES = `SLC_SEQ_LIMIT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    slc_reg_if.dev regBus,
    input wire logic [1:0] remotePresent,
    input wire logic pllLocked,
    input wire logic wordAligned,
    output logic [1:0] fwdRate,
    output logic [1:0] revRate,
    output logic [1:0] linkMode,
    output logic [1:0] portEnable,
    output logic phyReset,
    output logic calibrate,
    output logic adapt,
    output logic linkLock
);

    // ****************************************************
    // Declarations
    // ****************************************************
    localparam int CW = 20; // Counter width, holds the 50 ms budget

    slc_dev_state_t state_reg; // Sequence state
    slc_dev_state_t stateNext;
    logic [7:0] rateReg_reg; // Rate register contents
    logic [7:0] linkReg_reg; // Link register, one-shot bit kept apart
    logic oneshot_reg; // Pending one-shot reset
    logic oneshot_next;
    logic [1:0] fwdRate_reg; // Applied forward rate
    logic [1:0] revRate_reg; // Applied reverse rate
    logic [1:0] mode_reg; // Applied link mode
    logic [1:0] mode_next;
    logic auto_reg; // Applied automatic selection
    logic [CW-1:0] stepCnt_reg; // Calibrate and adapt timer
    logic [CW-1:0] budget_reg; // Sequence time budget
    logic [3:0] syncA_reg; // First synchroniser stage
    logic [3:0] syncB_reg; // Second synchroniser stage
    logic [7:0] rdData_reg; // Read answer byte
    logic rdValid_reg; // Read answer strobe

    // Port enables for a link mode; reused for outputs and status
    function automatic logic [1:0] portsFor(input logic [1:0] mode);
        case (mode)
            `SLC_CFG_FIRST: portsFor = 2'h1;
            `SLC_CFG_SECOND: portsFor = 2'h2;
            default: portsFor = 2'h3;
        endcase
    endfunction

    // ****************************************************
    // Register decode
    // ****************************************************
    wire logic wrRate = regBus.regWrEn && (regBus.regAddr == `SLC_REG_RATE);
    wire logic wrLink = regBus.regWrEn && (regBus.regAddr == `SLC_REG_LINK);
    wire logic launch = wrLink && regBus.regWrData[`SLC_BIT_ONESHOT];
    wire logic launchAuto = regBus.regWrData[`SLC_BIT_AUTO] || (NUM_PHYS == 1);
    wire logic [1:0] launchCfg = regBus.regWrData[`SLC_CFG_MSB:`SLC_CFG_LSB];
    wire logic [1:0] txField = rateReg_reg[`SLC_TX_MSB:`SLC_TX_LSB];
    wire logic [1:0] rxField = rateReg_reg[`SLC_RX_MSB:`SLC_RX_LSB];
    wire logic presA = syncB_reg[2];
    wire logic presB = syncB_reg[3] && (NUM_PHYS > 1);
    wire logic linkOk = syncB_reg[1] && syncB_reg[0];
    wire logic seqBusy = !(state_reg == S_IDLE || state_reg == S_LOCKED);
    wire logic [7:0] linkRead = {linkReg_reg[7:6], oneshot_reg, linkReg_reg[4:0]};
    wire logic [7:0] statusRead = {linkLock, seqBusy, 2'h0, mode_reg, portEnable};
    wire logic [7:0] rdSel = (regBus.regAddr == `SLC_REG_RATE) ? rateReg_reg :
                             (regBus.regAddr == `SLC_REG_LINK) ? linkRead :
                             (regBus.regAddr == `SLC_REG_STATUS) ? statusRead : 8'h00;
    wire logic stepDone = ((state_reg == S_CALIB) && (stepCnt_reg == CW'(CAL_CYCLES - 1))) ||
                          ((state_reg == S_ADAPT) && (stepCnt_reg == CW'(ADAPT_CYCLES - 1)));
    wire logic budgetOut = budget_reg == CW'(LIMIT_CYCLES - 1);
    wire slc_dev_state_t retryState = auto_reg ? S_DETECT : S_RESET;

    // ****************************************************
    // Outputs
    // ****************************************************
    assign fwdRate = fwdRate_reg;
    assign revRate = revRate_reg;
    assign linkMode = mode_reg;
    assign portEnable = portsFor(mode_reg);
    assign phyReset = state_reg == S_RESET;
    assign calibrate = state_reg == S_CALIB;
    assign adapt = state_reg == S_ADAPT;
    assign linkLock = state_reg == S_LOCKED;
    assign regBus.regRdData = rdData_reg;
    assign regBus.regRdValid = rdValid_reg;

    // ****************************************************
    // Sequence control
    // ****************************************************
    // Next state; a fresh one-shot restarts the sequence from any step
    always_comb begin
        stateNext = state_reg;
        case (state_reg)
            S_IDLE: begin
                stateNext = S_IDLE;
            end
            S_DETECT: begin
                // Port A wins a tie, so only one port is ever taken
                if (presA || presB) begin
                    stateNext = S_RESET;
                end
            end
            S_RESET: begin
                stateNext = S_CALIB;
            end
            S_CALIB: begin
                if (stepDone) begin
                    stateNext = S_ADAPT;
                end
            end
            S_ADAPT: begin
                if (stepDone) begin
                    stateNext = S_LINKUP;
                end
            end
            S_LINKUP: begin
                // Give up at the budget and rerun rather than hang
                if (linkOk) begin
                    stateNext = S_LOCKED;
                end else if (budgetOut) begin
                    stateNext = retryState;
                end
            end
            S_LOCKED: begin
                // Loss of link reruns from reset in manual mode, from port detection in auto mode
                if (!linkOk) begin
                    stateNext = retryState;
                end
            end
            default: begin
                stateNext = S_IDLE;
            end
        endcase
        if (launch) begin
            stateNext = launchAuto ? S_DETECT : S_RESET;
        end
    end

    // Applied mode; manual field read only when selection is manual
    always_comb begin
        mode_next = mode_reg;
        if (launch) begin
            if (launchAuto) begin
                mode_next = `SLC_CFG_FIRST;
            end else begin
                mode_next = launchCfg;
            end
        end else if (state_reg == S_DETECT && (presA || presB)) begin
            mode_next = presA ? `SLC_CFG_FIRST : `SLC_CFG_SECOND;
        end
    end

    // Set wins over the self-clear so a late write is never lost
    always_comb begin
        if (launch) begin
            oneshot_next = 1'b1;
        end else if (state_reg == S_RESET) begin
            oneshot_next = 1'b0;
        end else begin
            oneshot_next = oneshot_reg;
        end
    end

    // State and counters
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= S_IDLE;
            stepCnt_reg <= '0;
            budget_reg <= '0;
        end else begin
            state_reg <= stateNext;
            stepCnt_reg <= (stateNext != state_reg) ? '0 : stepCnt_reg + 1'b1;
            budget_reg <= (state_reg == S_RESET) ? '0 :
                          budgetOut ? budget_reg : budget_reg + 1'b1;
        end
    end

    // Rates and auto bit latch only at launch, mode also at detection; never on a plain write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fwdRate_reg <= `SLC_RATE_6G;
            revRate_reg <= `SLC_RATE_REV;
            mode_reg <= `SLC_CFG_FIRST;
            auto_reg <= 1'b1;
        end else begin
            if (launch) begin
                fwdRate_reg <= IS_SERIALIZER ? txField : rxField;
                revRate_reg <= IS_SERIALIZER ? rxField : txField;
                auto_reg <= launchAuto;
            end
            mode_reg <= mode_next;
        end
    end

    // ****************************************************
    // Register file and synchroniser
    // ****************************************************
    // Software-visible registers and read answer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rateReg_reg <= `SLC_RATE_RESET;
            linkReg_reg <= `SLC_LINK_RESET;
            oneshot_reg <= 1'b0;
            rdData_reg <= 8'h00;
            rdValid_reg <= 1'b0;
        end else begin
            if (wrRate) begin
                rateReg_reg <= regBus.regWrData;
            end
            if (wrLink) begin
                linkReg_reg <= regBus.regWrData & ~`SLC_ONESHOT_MASK;
            end
            oneshot_reg <= oneshot_next;
            rdData_reg <= regBus.regRdEn ? rdSel : rdData_reg;
            rdValid_reg <= regBus.regRdEn;
        end
    end

    // Two-stage synchroniser for the PHY status pins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            syncA_reg <= 4'h0;
            syncB_reg <= 4'h0;
        end else begin
            syncA_reg <= {remotePresent, pllLocked, wordAligned};
            syncB_reg <= syncA_reg;
        end
    end

endmodule

// ### verilog/slc_host_end.sv
`timescale 1ns/1ns
`include "slc_consts.svh"

// ****************************************************
// Configuring end: writes settings, fires one-shot, polls lock
// ****************************************************
module slc_host_end
    import slc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    slc_reg_if.host regBus,
    input wire logic cmdValid,
    input wire slc_cmd_t cmdKind,
    input wire logic [7:0] cmdData,
    output logic cmdReady,
    output logic linkUp
);

    // ****************************************************
    // Declarations
    // ****************************************************
    slc_host_state_t state_reg; // Sequencer state
    logic [7:0] shadow_reg; // Link byte without one-shot bit
    logic [15:0] addr_reg; // Bus address
    logic [7:0] wrData_reg; // Bus write byte
    logic wrEn_reg; // Bus write strobe
    logic rdEn_reg; // Bus read strobe
    logic linkUp_reg; // Last polled lock

    wire logic idleCmd = (state_reg == H_IDLE) && cmdValid;
    wire logic idlePoll = (state_reg == H_IDLE) && !cmdValid;
    wire logic [7:0] linkByte = shadow_reg | `SLC_ONESHOT_MASK;

    assign cmdReady = state_reg == H_IDLE;
    assign linkUp = linkUp_reg;
    assign regBus.regAddr = addr_reg;
    assign regBus.regWrData = wrData_reg;
    assign regBus.regWrEn = wrEn_reg;
    assign regBus.regRdEn = rdEn_reg;

    // ****************************************************
    // Sequencer
    // ****************************************************
    // Every change is followed by a link write with the one-shot bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= H_IDLE;
            shadow_reg <= `SLC_LINK_RESET;
            addr_reg <= 16'h0000;
            wrData_reg <= 8'h00;
            wrEn_reg <= 1'b0;
            rdEn_reg <= 1'b0;
            linkUp_reg <= 1'b0;
        end else begin
            wrEn_reg <= 1'b0;
            rdEn_reg <= 1'b0;
            case (state_reg)
                H_IDLE: begin
                    if (idleCmd && cmdKind == CMD_RATE) begin
                        // Rate written first, link reset follows
                        addr_reg <= `SLC_REG_RATE;
                        wrData_reg <= cmdData;
                        wrEn_reg <= 1'b1;
                        state_reg <= H_LINK;
                    end else if (idleCmd) begin
                        shadow_reg <= cmdData & ~`SLC_ONESHOT_MASK;
                        state_reg <= H_LINK;
                    end else if (idlePoll) begin
                        // Lock is polled, never assumed after a wait
                        addr_reg <= `SLC_REG_STATUS;
                        rdEn_reg <= 1'b1;
                        state_reg <= H_WAITRD;
                    end
                end
                H_LINK: begin
                    addr_reg <= `SLC_REG_LINK;
                    wrData_reg <= linkByte;
                    wrEn_reg <= 1'b1;
                    linkUp_reg <= 1'b0;
                    state_reg <= H_IDLE;
                end
                H_WAITRD: begin
                    if (regBus.regRdValid) begin
                        linkUp_reg <= regBus.regRdData[`SLC_STAT_LOCK];
                        state_reg <= H_IDLE;
                    end
                end
                default: begin
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

endmodule

// ### sim/slc_link_props.sv
`timescale 1ns/1ns
`include "slc_consts.svh"

// ****************************************************
// Checker beside the link between both ends
// ****************************************************
module slc_link_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic pllLocked,
    input wire logic [1:0] fwdRate,
    input wire logic [1:0] revRate,
    input wire logic [1:0] linkMode,
    input wire logic [1:0] portEnable,
    input wire logic phyReset,
    input wire logic calibrate,
    input wire logic adapt,
    input wire logic linkLock
);
    logic [7:0] rate_reg; // Last byte written to the rate register
    wire fire = regWrEn && (regAddr == `SLC_REG_LINK) && regWrData[`SLC_BIT_ONESHOT];
    wire manualFire = fire && !regWrData[`SLC_BIT_AUTO]; // One-shot with a manual code
    wire [1:0] portWant = (linkMode == 2'h1 || linkMode == 2'h2) ? linkMode : 2'h3;

    // Track rate writes, so applied codes can be predicted at the one-shot
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rate_reg <= `SLC_RATE_RESET;
        end else if (regWrEn && (regAddr == `SLC_REG_RATE)) begin
            rate_reg <= regWrData;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Counts match the shortened CAL_CYCLES and ADAPT_CYCLES of the bench
    sequence calSteps;
        calibrate [*5] ##1 adapt [*5];
    endsequence

    a_rd_answer: assert property (1'b1 |=> regRdValid == $past(regRdEn))
        else $error("Read answer strobe not one cycle after request");
    a_fire_reset: assert property (manualFire |=> phyReset)
        else $error("Manual one-shot did not reset the link");
    a_auto_detect: assert property (fire && regWrData[`SLC_BIT_AUTO] |=> !phyReset)
        else $error("Auto one-shot skipped port detection");
    a_seq_order: assert property (phyReset |=> calSteps)
        else $error("Calibrate and adapt steps out of order");
    a_manual_mode: assert property (
        manualFire |=> linkMode == $past(regWrData[1:0]))
        else $error("Applied link mode differs from written code");
    a_rate_apply: assert property (
        fire |=> fwdRate == $past(rate_reg[3:2]) && revRate == $past(rate_reg[1:0]))
        else $error("Applied rates differ from rate register");
    a_port_decode: assert property (portEnable == portWant)
        else $error("Port enables disagree with link mode");
    a_lock_busy: assert property ((phyReset || calibrate || adapt) |-> !linkLock)
        else $error("Lock high during reset sequence");
    a_lock_loss: assert property ((!pllLocked) [*4] |-> !linkLock)
        else $error("Lock stays high without PLL lock");
    a_status_lock: assert property (
        regRdValid && $past(regAddr) == `SLC_REG_STATUS |->
        regRdData[`SLC_STAT_LOCK] == $past(linkLock) &&
        regRdData[3:0] == $past({linkMode, portEnable}))
        else $error("Status byte disagrees with device state");
endmodule

// ### sim/tb_serial_link_mode_rate_config.sv
`timescale 1ns/1ns
`include "slc_consts.svh"

// ****************************************************
// Bench: configuring end and device end face each other
// ****************************************************
module tb_serial_link_mode_rate_config
    import slc_pkg::*;
;
    typedef struct packed {
        slc_cmd_t kind;
        logic [7:0] data;
        logic [1:0] remote;
        logic [7:0] want; // {fwdRate, revRate, linkMode, portEnable}
    } slc_row_t;

    logic sys_clk = 1'b0; // 100 ns period
    logic rst; // Synchronous, high
    logic cmdValid, cmdReady, linkUp, phyReset, calibrate, adapt, linkLock, linkLock2;
    slc_cmd_t cmdKind;
    logic [7:0] cmdData, q; // Command byte, last read byte
    logic [1:0] remotePresent, fwdRate, revRate, linkMode, portEnable;
    logic [1:0] fwdRate2, revRate2, linkMode2, portEnable2;
    logic pllLocked, wordAligned; // Shared by both devices
    int mismatches = 0;
    int compares = 0;
    int n;
    slc_row_t rows [9];
    localparam int SHORT = 5; // Calibrate and adapt cycles, cut so the run stays short
    localparam int LIMIT = 40; // Sequence budget in cycles, still above a full pass

    slc_reg_if linkBus(); // Joins host and device
    slc_reg_if tbBus(); // Bench acts as host of the second device

    slc_host_end slc_host_end_inst (.sys_clk, .rst, .regBus(linkBus.host), .cmdValid,
        .cmdKind, .cmdData, .cmdReady, .linkUp);
    slc_device_end #(.CAL_CYCLES(SHORT), .ADAPT_CYCLES(SHORT), .LIMIT_CYCLES(LIMIT))
        slc_device_end_inst (
        .sys_clk, .rst, .regBus(linkBus.dev), .remotePresent, .pllLocked, .wordAligned,
        .fwdRate, .revRate, .linkMode, .portEnable, .phyReset, .calibrate, .adapt, .linkLock);
    // Single-port deserializer, reached only through the bench
    slc_device_end #(.IS_SERIALIZER(1'b0), .NUM_PHYS(1), .CAL_CYCLES(SHORT),
        .ADAPT_CYCLES(SHORT), .LIMIT_CYCLES(LIMIT)) slc_device_end_inst_b (
        .sys_clk, .rst, .regBus(tbBus.dev), .remotePresent, .pllLocked, .wordAligned,
        .fwdRate(fwdRate2), .revRate(revRate2), .linkMode(linkMode2), .portEnable(portEnable2),
        .phyReset(), .calibrate(), .adapt(), .linkLock(linkLock2));
    slc_link_props slc_link_props_inst (.sys_clk, .rst, .regAddr(linkBus.regAddr),
        .regWrData(linkBus.regWrData), .regWrEn(linkBus.regWrEn), .regRdEn(linkBus.regRdEn),
        .regRdData(linkBus.regRdData), .regRdValid(linkBus.regRdValid), .pllLocked,
        .fwdRate, .revRate, .linkMode, .portEnable, .phyReset, .calibrate, .adapt, .linkLock);

    // Clock
    always #50 sys_clk = ~sys_clk;

    // Inputs move 1 ns after the rising edge, away from sampling
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic sel(input int w);
        case (w)
            0: return phyReset === 1'b1;
            1: return linkLock === 1'b1;
            2: return linkUp === 1'b1;
            default: return linkLock2 === 1'b1;
        endcase
    endfunction

    // Bounded wait; the limit doubles as the latency bound under test
    task automatic waitf(input int w, input int lim);
        for (n = 0; n < lim; n++) begin
            if (sel(w)) break;
            step();
        end
        compares++;
        if (n == lim) begin
            mismatches++;
            $display("Error wait %0d expected 1 seen timeout", w);
        end
    endtask

    // Hold the command until the edge that takes it
    task automatic send(input slc_cmd_t k, input logic [7:0] d);
        cmdKind = k;
        cmdData = d;
        cmdValid = 1'b1;
        for (n = 0; n < 20 && cmdReady !== 1'b1; n++) step();
        step();
        cmdValid = 1'b0;
    endtask

    // Strobes are spaced by a cycle, so no signal is set twice in one step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        tbBus.regAddr = a;
        tbBus.regWrData = d;
        tbBus.regWrEn = 1'b1;
        step();
        tbBus.regWrEn = 1'b0;
        step();
    endtask

    task automatic rd(input logic [15:0] a);
        tbBus.regAddr = a;
        tbBus.regRdEn = 1'b1;
        step();
        tbBus.regRdEn = 1'b0;
        check("read valid", 8'h01, {7'h0, tbBus.regRdValid});
        q = tbBus.regRdData;
        step();
    endtask

    task automatic close_out();
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog, far beyond the roughly 250 cycles of the tests
    initial begin
        #400000;
        mismatches++;
        close_out();
    end

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        // Auto selection stays on for rate rows; 0x21, 0x22 and 0x02 pick a port by hand
        rows = '{'{CMD_RATE, 8'h48, 2'h3, 8'h85}, '{CMD_MODE, 8'h22, 2'h3, 8'h8a},
            '{CMD_MODE, 8'h21, 2'h3, 8'h85}, '{CMD_MODE, 8'h23, 2'h3, 8'h8f},
            '{CMD_MODE, 8'h00, 2'h3, 8'h83}, '{CMD_MODE, 8'h30, 2'h2, 8'h8a},
            '{CMD_MODE, 8'h13, 2'h1, 8'h85}, '{CMD_RATE, 8'h44, 2'h1, 8'h45},
            '{CMD_MODE, 8'h02, 2'h3, 8'h4a}};
        rst = 1'b1;
        {cmdValid, cmdData} = '0;
        cmdKind = CMD_MODE;
        {remotePresent, pllLocked, wordAligned} = 4'hf;
        {tbBus.regAddr, tbBus.regWrData, tbBus.regWrEn, tbBus.regRdEn} = '0;
        repeat (10) step();
        check("reset outputs", 8'h85, {fwdRate, revRate, linkMode, portEnable});
        check("reset flags", 8'h01, {5'h0, linkLock, linkUp, cmdReady});
        rst = 1'b0;
        $display("Test reset done");

        // Host writes settings then the one-shot for every row
        for (int i = 0; i < 9; i++) begin
            remotePresent = rows[i].remote;
            send(rows[i].kind, rows[i].data);
            waitf(0, 20);
            waitf(1, 30);
            check("applied", rows[i].want, {fwdRate, revRate, linkMode, portEnable});
            waitf(2, 10);
        end
        $display("Test rows done");

        // Link loss drops lock, recovery keeps the manual mode
        pllLocked = 1'b0;
        repeat (4) step();
        check("lock on loss", 8'h00, {7'h0, linkLock});
        pllLocked = 1'b1;
        waitf(1, 60);
        check("mode kept", 8'h4a, {fwdRate, revRate, linkMode, portEnable});
        // Losing word alignment alone must also drop lock
        wordAligned = 1'b0;
        repeat (4) step();
        check("lock on misalign", 8'h00, {7'h0, linkLock});
        wordAligned = 1'b1;
        waitf(1, 60);
        $display("Test link loss done");

        // Second device: reset values, no one-shot, pending bit
        remotePresent = 2'h1;
        rd(`SLC_REG_RATE);
        check("rate reset", 8'h08, q);
        rd(`SLC_REG_LINK);
        check("link reset", 8'h10, q);
        wr(`SLC_REG_RATE, 8'h01);
        wr(`SLC_REG_LINK, 8'h03);
        step();
        check("no apply", 8'h85, {fwdRate2, revRate2, linkMode2, portEnable2});
        rd(`SLC_REG_RATE);
        check("rate stored", 8'h01, q);
        rd(16'h0050);
        check("unmapped", 8'h00, q);
        tbBus.regAddr = `SLC_REG_LINK;
        tbBus.regWrData = 8'h23;
        tbBus.regWrEn = 1'b1;
        step();
        tbBus.regWrEn = 1'b0;
        tbBus.regRdEn = 1'b1;
        step();
        tbBus.regRdEn = 1'b0;
        check("pending", 8'h20, tbBus.regRdData & `SLC_ONESHOT_MASK);
        waitf(3, 40);
        check("deser applied", 8'h45, {fwdRate2, revRate2, linkMode2, portEnable2});
        rd(`SLC_REG_LINK);
        check("cleared", 8'h00, q & `SLC_ONESHOT_MASK);
        rd(`SLC_REG_STATUS);
        check("status", 8'h85, q);
        $display("Test second device done");

        // Restart in mid-sequence, then deserializer rate 0x02
        wr(`SLC_REG_RATE, 8'h02);
        wr(`SLC_REG_LINK, 8'h20);
        wr(`SLC_REG_LINK, 8'h21);
        waitf(3, 40);
        check("restart", 8'h85, {fwdRate2, revRate2, linkMode2, portEnable2});
        $display("Test restart done");
        close_out();
    end
endmodule
